// ==== common/jtd_pkg.sv ====
// Purpose: Shared constants and types for the test access port link.
// Assumes: Five-bit instruction register, 32-bit debug data register.
// Notes:   Instruction codes are arbitrary choices of this block.
`default_nettype none
package jtd_pkg;
    // ************************************************************
    // Widths and codes
    // ************************************************************
    localparam int          IR_LEN        = 5;
    localparam int          DR_LEN        = 32;
    localparam logic [4:0]  IR_RESET_VAL  = 5'h01;  // Reset selects the identity path
    localparam logic [4:0]  IR_CAPTURE    = 5'h01;  // Fixed capture pattern
    localparam logic [4:0]  INS_IDCODE    = 5'h01;
    localparam logic [4:0]  INS_DBG_REQ   = 5'h07;  // Request debug mode
    localparam logic [4:0]  INS_DBG_DATA  = 5'h08;  // Debug data register
    localparam logic [4:0]  INS_DBG_GO    = 5'h09;  // Leave debug mode
    localparam logic [4:0]  INS_BYPASS    = 5'h1f;
    localparam logic [31:0] ID_VALUE      = 32'h0000_0001; // Arbitrary value
    localparam int          EVT_CYCLES    = 3;      // Debug event pulse length
    localparam int          TRST_CYCLES   = 2;      // Host reset hold is one tck more than this
    localparam int          TCK_DIV       = 4;      // Host sys_clk per tck half

    // ************************************************************
    // Controller states
    // ************************************************************
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PAU_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PAU_IR, EX2_IR, UPD_IR
    } jtd_tap_type;

    // Standard sixteen-state next-state map
    function automatic jtd_tap_type jtd_next(input jtd_tap_type s,
                                             input logic        tms);
        case (s)
            TLR:     jtd_next = tms ? TLR    : RTI;
            RTI:     jtd_next = tms ? SEL_DR : RTI;
            SEL_DR:  jtd_next = tms ? SEL_IR : CAP_DR;
            CAP_DR:  jtd_next = tms ? EX1_DR : SH_DR;
            SH_DR:   jtd_next = tms ? EX1_DR : SH_DR;
            EX1_DR:  jtd_next = tms ? UPD_DR : PAU_DR;
            PAU_DR:  jtd_next = tms ? EX2_DR : PAU_DR;
            EX2_DR:  jtd_next = tms ? UPD_DR : SH_DR;
            UPD_DR:  jtd_next = tms ? SEL_DR : RTI;
            SEL_IR:  jtd_next = tms ? TLR    : CAP_IR;
            CAP_IR:  jtd_next = tms ? EX1_IR : SH_IR;
            SH_IR:   jtd_next = tms ? EX1_IR : SH_IR;
            EX1_IR:  jtd_next = tms ? UPD_IR : PAU_IR;
            PAU_IR:  jtd_next = tms ? EX2_IR : PAU_IR;
            EX2_IR:  jtd_next = tms ? UPD_IR : SH_IR;
            UPD_IR:  jtd_next = tms ? SEL_DR : RTI;
            default: jtd_next = TLR;
        endcase
    endfunction
endpackage
`default_nettype wire

// ==== common/jtd_link_if.sv ====
// Purpose: Pin bundle between the test controller and the device.
// Assumes: Open-drain event pin is low when either end pulls it.
// Notes:   No clocking block; the bench joins the two ends.
`timescale 1ns/1ns
`default_nettype none
interface jtd_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe;
    logic trst_n;
    logic dev_evt_oe;   // Device pulls the event pin low
    logic host_evt_oe;  // Controller pulls the event pin low
    logic evt_n;        // Resolved pin level

    // Pull-up with wired-low drivers
    assign evt_n = ~(dev_evt_oe | host_evt_oe);

    modport dev  (input tck, tms, tdi, trst_n, evt_n,
                  output tdo, tdo_oe, dev_evt_oe);
    modport host (output tck, tms, tdi, trst_n, host_evt_oe,
                  input tdo, tdo_oe, evt_n);
endinterface
`default_nettype wire

// ==== hw/jtd_device.sv ====
// Purpose: Device end: test controller, debug data path, event pin.
// Assumes: Core runs on sys_clk; tck is its own domain.
// Notes:   Core side is a small halt and register-access port.
//
// Contract
// - Standard boundary-scan test access architecture
// - Test logic clocked by test clock
// - Sample data input on rising edge
// - Mode select steps controller on rising
// - Drive data output only in shifts
// - Data output changes on falling edge
// - Test reset initializes controller asynchronously
// - Controller asserts test reset after power-up
// - External event input starts debug mode
// - Core finishes instruction, saves pipeline, halts
// - Halted until serial commands arrive
// - Event pin driven open-drain only
// - Event output pulses three core cycles
// - All other debug traffic via port
// - Debug reads do not disturb operation
`timescale 1ns/1ns
`default_nettype none
module jtd_device
    import jtd_pkg::*;
(
    input  wire logic                   sys_clk,
    input  wire logic                   resetn,
    jtd_link_if.dev                     link,
    input  wire logic                   core_instr_done,
    input  wire logic                   core_bkpt_hit,
    input  wire logic [jtd_pkg::DR_LEN-1:0] core_read_data,
    output var  logic                   core_halt,
    output var  logic                   core_save_pipe,
    output var  logic                   core_in_debug
);
    import jtd_pkg::*;

    // ************************************************************
    // Test clock domain state
    // ************************************************************
    typedef struct packed {
        jtd_tap_type         st;
        logic [IR_LEN-1:0]   ir;
        logic [IR_LEN-1:0]   ir_sh;
        logic [DR_LEN-1:0]   dr_sh;
        logic                byp;
        logic                req_tgl;  // Toggle: request debug
        logic                go_tgl;   // Toggle: leave debug
    } jtd_tck_type;

    jtd_tck_type t_q, t_d;
    logic        tdo_q;
    logic        tdo_oe_q;
    logic [DR_LEN-1:0] snap_sync1_q, snap_sync2_q;

    // Next state of the test controller
    always_comb begin
        t_d = t_q;
        t_d.st = jtd_next(t_q.st, link.tms);
        case (t_q.st)
            TLR: begin
                t_d.ir = IR_RESET_VAL;
            end
            CAP_IR: begin
                t_d.ir_sh = IR_CAPTURE;
            end
            SH_IR: begin
                t_d.ir_sh = {link.tdi, t_q.ir_sh[IR_LEN-1:1]};
            end
            UPD_IR: begin
                t_d.ir = t_q.ir_sh;
                if (t_q.ir_sh == INS_DBG_REQ) begin
                    t_d.req_tgl = ~t_q.req_tgl;
                end
                if (t_q.ir_sh == INS_DBG_GO) begin
                    t_d.go_tgl = ~t_q.go_tgl;
                end
            end
            CAP_DR: begin
                t_d.byp = 1'b0;
                case (t_q.ir)
                    INS_IDCODE:   t_d.dr_sh = ID_VALUE;
                    INS_DBG_DATA: t_d.dr_sh = snap_sync2_q;
                    default:      t_d.dr_sh = '0;
                endcase
            end
            SH_DR: begin
                t_d.byp   = link.tdi;
                t_d.dr_sh = {link.tdi, t_q.dr_sh[DR_LEN-1:1]};
            end
            default: begin
            end
        endcase
    end

    // Rising-edge registers, reset asynchronously by test reset
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            t_q.st      <= TLR;
            t_q.ir      <= IR_RESET_VAL;
            t_q.ir_sh   <= '0;
            t_q.dr_sh   <= '0;
            t_q.byp     <= 1'b0;
            t_q.req_tgl <= 1'b0;
            t_q.go_tgl  <= 1'b0;
        end else begin
            t_q <= t_d;
        end
    end

    // Falling-edge output stage; floats outside shifts
    always_ff @(negedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            tdo_q    <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else begin
            tdo_oe_q <= (t_q.st == SH_IR) || (t_q.st == SH_DR);
            if (t_q.st == SH_IR) begin
                tdo_q <= t_q.ir_sh[0];
            end else if (t_q.ir == INS_BYPASS) begin
                tdo_q <= t_q.byp;
            end else begin
                tdo_q <= t_q.dr_sh[0];
            end
        end
    end

    assign link.tdo    = tdo_q;
    assign link.tdo_oe = tdo_oe_q;

    // Core data snapshot crosses as a quasi-static word, two stages
    always_ff @(posedge link.tck or negedge link.trst_n) begin
        if (!link.trst_n) begin
            snap_sync1_q <= '0;
            snap_sync2_q <= '0;
        end else begin
            snap_sync1_q <= core_read_data;
            snap_sync2_q <= snap_sync1_q;
        end
    end

    // ************************************************************
    // Core clock domain state
    // ************************************************************
    typedef enum {RUN, FINISH, SAVE, HALT} jtd_core_type;

    typedef struct packed {
        jtd_core_type core_st;
        logic [2:0]   req_s;     // Toggle synchroniser plus history
        logic [2:0]   go_s;
        logic [1:0]   evt_s;     // Event pin synchroniser
        logic         evt_prev;
        logic         pend;
        logic [1:0]   pulse_cnt;
        logic         evt_oe;
        logic         halt;
        logic         save;
        logic         dbg;
    } jtd_sys_type;

    jtd_sys_type s_q, s_d;

    // Debug entry, exit and event pulse
    always_comb begin
        s_d = s_q;
        s_d.req_s    = {s_q.req_s[1:0], t_q.req_tgl};
        s_d.go_s     = {s_q.go_s[1:0], t_q.go_tgl};
        s_d.evt_s    = {s_q.evt_s[0], link.evt_n};
        s_d.evt_prev = s_q.evt_s[1];
        s_d.save     = 1'b0;
        // Entry clears the request; a new request in that cycle wins
        if (s_q.core_st == SAVE) begin
            s_d.pend = 1'b0;
        end
        // External falling edge on the pin while our pull is idle
        if ((s_q.evt_prev && !s_q.evt_s[1] && !s_q.evt_oe)
            || (s_q.req_s[2] != s_q.req_s[1])) begin
            s_d.pend = 1'b1;
        end
        if (s_q.pulse_cnt != 2'h0) begin
            s_d.pulse_cnt = s_q.pulse_cnt - 2'h1;
        end
        s_d.evt_oe = (s_d.pulse_cnt != 2'h0);
        case (s_q.core_st)
            RUN: begin
                if (s_q.pend || core_bkpt_hit) begin
                    s_d.core_st = FINISH;
                end
            end
            FINISH: begin
                if (core_instr_done) begin
                    s_d.core_st = SAVE;
                    s_d.save    = 1'b1;
                end
            end
            SAVE: begin
                s_d.core_st   = HALT;
                s_d.halt      = 1'b1;
                s_d.dbg       = 1'b1;
                s_d.pulse_cnt = 2'(EVT_CYCLES);
                s_d.evt_oe    = 1'b1;
            end
            HALT: begin
                if (s_q.go_s[2] != s_q.go_s[1]) begin
                    s_d.core_st = RUN;
                    s_d.halt    = 1'b0;
                    s_d.dbg     = 1'b0;
                end
            end
            default: begin
                s_d.core_st = RUN;
            end
        endcase
    end

    // Core-domain registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{core_st: RUN, evt_s: 2'h3, evt_prev: 1'b1,
                     default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.dev_evt_oe = s_q.evt_oe;
    assign core_halt       = s_q.halt;
    assign core_save_pipe  = s_q.save;
    assign core_in_debug   = s_q.dbg;
endmodule
`default_nettype wire

// ==== hw/jtd_host.sv ====
// Purpose: Controller end: drives tck by division and runs commands.
// Assumes: One command at a time, taken when ready is high.
// Notes:   Commands: 0 reset walk, 1 instruction scan, 2 data scan.
`timescale 1ns/1ns
`default_nettype none
module jtd_host
    import jtd_pkg::*;
(
    input  wire logic                       sys_clk,
    input  wire logic                       resetn,
    jtd_link_if.host                        link,
    input  wire logic                       cmd_valid,
    input  wire logic [1:0]                 cmd_op,
    input  wire logic [jtd_pkg::DR_LEN-1:0] cmd_data,
    input  wire logic                       dbg_req,
    output var  logic                       cmd_ready,
    output var  logic [jtd_pkg::DR_LEN-1:0] rsp_data,
    output var  logic                       rsp_valid,
    output var  logic                       dbg_seen
);
    import jtd_pkg::*;

    typedef enum {PWR, IDLE, TMS_SEQ, SHIFT, TAIL} jtd_hst_type;

    typedef struct packed {
        jtd_hst_type st;
        logic [7:0]  div;
        logic        tck;
        logic        tms;
        logic        tdi;
        logic        trst_n;
        logic [15:0] seq;       // Select pattern, LSB first
        logic [4:0]  seq_n;
        logic [5:0]  bits;
        logic [DR_LEN-1:0] sh;
        logic [DR_LEN-1:0] cap;
        logic        is_ir;
        logic        rdy;
        logic        rv;
        logic [1:0]  evt_s;
        logic        evt_oe;
        logic [1:0]  oe_hist;   // Own pull, delayed like the pin
        logic [1:0]  tdo_s;     // Data output synchroniser
        logic        seen;
    } jtd_h_type;

    jtd_h_type h_q, h_d;
    logic      rise;
    logic      fall;

    // Edge markers of the divided test clock
    assign rise = (h_q.div == 8'(TCK_DIV - 1)) && !h_q.tck;
    assign fall = (h_q.div == 8'(TCK_DIV - 1)) && h_q.tck;

    always_comb begin
        h_d = h_q;
        h_d.rv    = 1'b0;
        h_d.div   = (h_q.div == 8'(TCK_DIV - 1)) ? 8'h00 : h_q.div + 8'h01;
        h_d.tck   = (rise || fall) ? ~h_q.tck : h_q.tck;
        h_d.evt_s = {h_q.evt_s[0], link.evt_n};
        h_d.tdo_s = {h_q.tdo_s[0], link.tdo};
        h_d.evt_oe = dbg_req;
        // Own pull delayed to line up with the pin synchroniser
        h_d.oe_hist = {h_q.oe_hist[0], h_q.evt_oe};
        case (h_q.st)
            PWR: begin
                h_d.trst_n = 1'b0;
                if (fall) begin
                    h_d.seq_n = h_q.seq_n + 5'h01;
                    if (h_q.seq_n == 5'(TRST_CYCLES)) begin
                        h_d.trst_n = 1'b1;
                        h_d.st     = IDLE;
                        h_d.rdy    = 1'b1;
                    end
                end
            end
            IDLE: begin
                if (cmd_valid && h_q.rdy) begin
                    h_d.rdy   = 1'b0;
                    h_d.seen  = 1'b0;
                    h_d.sh    = cmd_data;
                    h_d.is_ir = (cmd_op == 2'h1);
                    h_d.st    = TMS_SEQ;
                    case (cmd_op)
                        2'h1: begin  // RTI->SEL_DR->SEL_IR->CAP->SH
                            h_d.seq = 16'h0003; h_d.seq_n = 5'h04;
                            h_d.bits = 6'(IR_LEN);
                        end
                        2'h2: begin
                            h_d.seq = 16'h0001; h_d.seq_n = 5'h03;
                            h_d.bits = 6'(DR_LEN);
                        end
                        default: begin  // Five highs then idle
                            h_d.seq = 16'h001f; h_d.seq_n = 5'h06;
                            h_d.bits = 6'h00;
                        end
                    endcase
                end
            end
            TMS_SEQ: begin
                if (fall) begin
                    h_d.tms   = h_q.seq[0];
                    h_d.seq   = {1'b0, h_q.seq[15:1]};
                    h_d.seq_n = h_q.seq_n - 5'h01;
                    if (h_q.seq_n == 5'h01) begin
                        h_d.st = (h_q.bits == 6'h00) ? IDLE : SHIFT;
                        h_d.rdy = (h_q.bits == 6'h00);
                        h_d.rv  = (h_q.bits == 6'h00);  // Walk answers here
                    end
                end
            end
            SHIFT: begin
                if (rise) begin  // Device output settled on fall
                    h_d.cap = {h_q.tdo_s[1], h_q.cap[DR_LEN-1:1]};
                end
                if (fall) begin
                    h_d.tdi  = h_q.sh[0];
                    h_d.sh   = {1'b0, h_q.sh[DR_LEN-1:1]};
                    h_d.bits = h_q.bits - 6'h01;
                    h_d.tms  = (h_q.bits <= 6'h01);  // Exit, then update
                    if (h_q.bits == 6'h00) begin
                        h_d.st    = TAIL;
                        h_d.seq   = 16'h0000;
                        h_d.seq_n = 5'h01;
                    end
                end
            end
            TAIL: begin  // UPDATE -> RTI
                if (fall) begin
                    h_d.tms   = h_q.seq[0];
                    h_d.seq   = {1'b0, h_q.seq[15:1]};
                    h_d.seq_n = h_q.seq_n - 5'h01;
                    if (h_q.seq_n == 5'h01) begin
                        h_d.st  = IDLE;
                        h_d.rdy = 1'b1;
                        h_d.rv  = 1'b1;
                    end
                end
            end
            default: h_d.st = PWR;
        endcase
        // Device pull seen on the pin; wins over the clear at a command
        if (!h_q.evt_s[1] && !h_q.oe_hist[1]) begin
            h_d.seen = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            h_q <= '{st: PWR, tms: 1'b1, evt_s: 2'h3, default: '0};
        end else begin
            h_q <= h_d;
        end
    end

    assign link.tck         = h_q.tck;
    assign link.tms         = h_q.tms;
    assign link.tdi         = h_q.tdi;
    assign link.trst_n      = h_q.trst_n;
    assign link.host_evt_oe = h_q.evt_oe;
    assign cmd_ready        = h_q.rdy;
    assign rsp_data         = h_q.cap;
    assign rsp_valid        = h_q.rv;
    assign dbg_seen         = h_q.seen;
endmodule
`default_nettype wire

// ==== sim/jtd_chk.sv ====
// Purpose: Watches the test access link between the two ends.
// Assumes: Sees only the link signals, the core clock and its reset.
// Notes:   Test clock checks are disabled while the test reset is low.
`timescale 1ns/1ns
`default_nettype none
module jtd_chk (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe,
    input wire logic trst_n,
    input wire logic dev_evt_oe,
    input wire logic host_evt_oe,
    input wire logic evt_n
);
    // ************************************************************
    // Helper logic
    // ************************************************************
    logic tdo_q;
    logic oe_q;

    // Output values seen at the rising test clock edge
    always_ff @(posedge tck or negedge trst_n) begin
        if (!trst_n) begin
            tdo_q <= 1'b0;
            oe_q  <= 1'b0;
        end else begin
            tdo_q <= tdo;
            oe_q  <= tdo_oe;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    five_high_idle_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        tms [*5] |=> !tdo_oe)
        else $error("output on after five high selects");
    tdo_fall_edge_a: assert property (
        @(negedge tck) disable iff (!trst_n)
        oe_q |-> tdo == tdo_q)
        else $error("data out moved while clock high");
    oe_fall_edge_a: assert property (
        @(negedge tck) disable iff (!trst_n)
        tdo_oe == oe_q)
        else $error("output enable moved while clock high");
    shift_entry_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        $rose(tdo_oe) |-> !$past(tms))
        else $error("output on without shift");
    shift_exit_a: assert property (
        @(posedge tck) disable iff (!trst_n)
        $fell(tdo_oe) |-> $past(tms))
        else $error("output off inside shift");
    trst_float_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !trst_n && $past(!trst_n) |-> !tdo_oe)
        else $error("output on in reset");
    trst_boot_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $rose(resetn) |-> !trst_n)
        else $error("no test reset after reset");
    evt_pulse_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $rose(dev_evt_oe) |-> dev_evt_oe [*3] ##1 !dev_evt_oe)
        else $error("event pulse not three cycles");
    evt_req_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        $rose(host_evt_oe) |-> ##[1:100] dev_evt_oe)
        else $error("no event answer to pin request");
    evt_wired_a: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        dev_evt_oe |-> !evt_n)
        else $error("event pin not pulled low");
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: Joins both ends and runs the link scenarios.
// Assumes: The controller end makes the test clock by division.
// Notes:   Inputs change on the falling core clock edge.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import jtd_pkg::*;
    logic        sys_clk;
    logic        resetn;
    logic        instr_done;
    logic        bkpt_hit;
    logic [31:0] read_data;
    logic        core_halt;
    logic        core_save_pipe;
    logic        core_in_debug;
    logic        cmd_valid;
    logic [1:0]  cmd_op;
    logic [31:0] cmd_data;
    logic        dbg_req;
    logic        cmd_ready;
    logic [31:0] rsp_data;
    logic        rsp_valid;
    logic        dbg_seen;
    int          fails;
    int          total_checks;
    int          cyc;
    int          evt_cnt;
    int          sv_cnt;

    jtd_link_if u_link ();
    jtd_device u_jtd_device (.sys_clk(sys_clk), .resetn(resetn),
        .link(u_link), .core_instr_done(instr_done),
        .core_bkpt_hit(bkpt_hit), .core_read_data(read_data),
        .core_halt(core_halt), .core_save_pipe(core_save_pipe),
        .core_in_debug(core_in_debug));
    jtd_host u_jtd_host (.sys_clk(sys_clk), .resetn(resetn),
        .link(u_link), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_data(cmd_data), .dbg_req(dbg_req), .cmd_ready(cmd_ready),
        .rsp_data(rsp_data), .rsp_valid(rsp_valid), .dbg_seen(dbg_seen));
    jtd_chk u_jtd_chk (.sys_clk(sys_clk), .resetn(resetn),
        .tck(u_link.tck), .tms(u_link.tms), .tdi(u_link.tdi),
        .tdo(u_link.tdo), .tdo_oe(u_link.tdo_oe), .trst_n(u_link.trst_n),
        .dev_evt_oe(u_link.dev_evt_oe), .host_evt_oe(u_link.host_evt_oe),
        .evt_n(u_link.evt_n));

    // ************************************************************
    // Clock, counters and timeout
    // ************************************************************
    // Core clock
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    // Event and save counts, cycle ceiling
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (u_link.dev_evt_oe === 1'b1) evt_cnt = evt_cnt + 1;
        if (core_save_pipe === 1'b1) sv_cnt = sv_cnt + 1;
        if (cyc == 60000) begin
            fails = fails + 1;
            results();
        end
    end

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic chk(input string nm, input logic [31:0] got, exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // One command through the controller end, waits for its answer
    task automatic run(input logic [1:0] op, input logic [31:0] d);
        int k;
        @(negedge sys_clk);
        cmd_op    = op;
        cmd_data  = d;
        cmd_valid = 1'b1;
        for (k = 0; k < 5000 && cmd_ready !== 1'b1; k++) @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        for (k = 0; k < 5000 && rsp_valid !== 1'b1; k++) @(negedge sys_clk);
        chk("rsp_valid", rsp_valid, 1'b1);
        chk("cmd_ready", cmd_ready, 1'b1);
    endtask

    // Waits for the halt, then judges save pulse and event length
    task automatic wait_halt();
        int k;
        for (k = 0; k < 300 && core_halt !== 1'b1; k++) @(negedge sys_clk);
        repeat (10) @(negedge sys_clk);
        chk("core_halt", core_halt, 1'b1);
        chk("core_in_debug", core_in_debug, 1'b1);
        chk("save_pulses", sv_cnt, 1);
        chk("event_cycles", evt_cnt, EVT_CYCLES);
    endtask

    task automatic clr();
        @(negedge sys_clk);
        evt_cnt = 0;
        sv_cnt  = 0;
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_idcode();
        run(2'd0, 32'h0);
        run(2'd2, 32'hffff_ffff);
        chk("idcode", rsp_data, ID_VALUE);
        chk("tdo_oe_idle", u_link.tdo_oe, 1'b0);
    endtask

    task automatic t_bypass();
        run(2'd1, {27'h0, INS_BYPASS});
        run(2'd2, 32'h8c3a_51e7);
        chk("bypass", rsp_data, {31'h0c3a_51e7, 1'b0});
    endtask

    task automatic t_read();
        run(2'd1, {27'h0, INS_DBG_DATA});
        run(2'd2, 32'h0);
        chk("debug_read", rsp_data, read_data);
        chk("no_halt", core_halt, 1'b0);
    endtask

    task automatic t_pin_req();
        clr();
        instr_done = 1'b0;
        dbg_req    = 1'b1;
        repeat (40) @(negedge sys_clk);
        chk("halt_early", core_halt, 1'b0);
        chk("save_early", sv_cnt, 0);
        dbg_req    = 1'b0;
        repeat (4) @(negedge sys_clk);
        instr_done = 1'b1;
        wait_halt();
        chk("dbg_seen", dbg_seen, 1'b1);
        repeat (60) @(negedge sys_clk);
        chk("still_halted", core_halt, 1'b1);
        run(2'd1, {27'h0, INS_DBG_GO});
        repeat (10) @(negedge sys_clk);
        chk("released", core_halt, 1'b0);
    endtask

    task automatic t_ir_req();
        clr();
        run(2'd1, {27'h0, INS_DBG_REQ});
        wait_halt();
        run(2'd1, {27'h0, INS_DBG_GO});
        repeat (10) @(negedge sys_clk);
        chk("released", core_halt, 1'b0);
    endtask

    task automatic t_bkpt();
        clr();
        bkpt_hit = 1'b1;
        @(negedge sys_clk);
        bkpt_hit = 1'b0;
        wait_halt();
        run(2'd1, {27'h0, INS_DBG_GO});
    endtask

    task automatic t_rst();
        @(negedge sys_clk);
        cmd_op    = 2'd2;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1 && cyc < 59000) @(negedge sys_clk);
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        repeat (80) @(negedge sys_clk);
        chk("oe_in_shift", u_link.tdo_oe, 1'b1);
        resetn = 1'b0;
        @(negedge sys_clk);
        chk("oe_in_reset", u_link.tdo_oe, 1'b0);
        repeat (4) @(negedge sys_clk);
        resetn = 1'b1;
        t_idcode();
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        resetn       = 1'b0;
        instr_done   = 1'b1;
        bkpt_hit     = 1'b0;
        read_data    = 32'h5a3c_96e1;
        cmd_valid    = 1'b0;
        cmd_op       = 2'd0;
        cmd_data     = 32'h0;
        dbg_req      = 1'b0;
        fails        = 0;
        total_checks = 0;
        cyc          = 0;
        evt_cnt      = 0;
        sv_cnt       = 0;
        repeat (5) @(negedge sys_clk);
        resetn = 1'b1;
        t_idcode();
        t_bypass();
        t_read();
        t_pin_req();
        t_ir_req();
        t_bkpt();
        t_rst();
        results();
    end
endmodule
`default_nettype wire
